// [logic/io_ports_regs.vh]
// Register map, field layout, reset values and pin-mode codes of the I/O port block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers, low byte used, low 16 bits for the capture mode registers.
`ifndef IO_PORTS_REGS_VH
`define IO_PORTS_REGS_VH

// Byte offsets in the io_register_window
`define OFS_IN_A     12'h000
`define OFS_IN_B     12'h004
`define OFS_IN_C     12'h008
`define OFS_IN_D     12'h00c
`define OFS_OUT_A    12'h010
`define OFS_OUT_B    12'h014
`define OFS_OUT_C    12'h018
`define OFS_OUT_D    12'h01c
`define OFS_DIR_A    12'h020
`define OFS_DIR_B    12'h024
`define OFS_DIR_C    12'h028
`define OFS_DIR_D    12'h02c
`define OFS_MODE_A   12'h030
`define OFS_MODE_B   12'h034
`define OFS_CAP_A    12'h038
`define OFS_CAP_B    12'h03c
`define OFS_CAP_C    12'h040
`define OFS_CELL_A   12'h044
`define OFS_CELL_B   12'h048
`define OFS_CELL_C   12'h04c
`define OFS_MCELL_LO 12'h050
`define OFS_MCELL_HI 12'h054

`define PORT_W       8
`define PORT_D_W     3
`define PORT_D_MASK  8'h07
`define CFG_RESET    8'h00

// Fixed per-pin output function codes, two bits per pin
`define FN_HOST      2'h0
`define FN_LOGIC     2'h1
`define FN_CS        2'h2
`define FN_DATA      2'h3

// Capture cell modes, two bits per pin
`define CAP_DIRECT   2'h0
`define CAP_LATCH    2'h1
`define CAP_EDGE     2'h2

`endif

// [logic/capture_cell_port.v]
// One port of eight input capture cells with a pin synchroniser.
// Assumes pins arrive asynchronously and strobes come from the same clock.
`timescale 1ns/1ps
`include "io_ports_regs.vh"

module capture_cell_port (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // Pins and strobes
  input  wire [7:0]  pin_i,
  input  wire        strobe_i,
  input  wire [15:0] mode_i,
  // Results
  output wire [7:0]  level_o,
  output wire [7:0]  cell_o
);

  reg  [7:0] s1_ff;
  reg  [7:0] s2_ff;
  reg  [7:0] s3_ff;
  reg  [7:0] stable_ff;
  reg  [7:0] strobe_dly_ff;
  reg  [7:0] cell_ff;
  reg  [7:0] nxt_cell;
  integer    k;

  ////////////////////////////////////////////////////////////////////////
  // Level only moves once stages two and three agree
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_ff     <= 8'h00;
      s2_ff     <= 8'h00;
      s3_ff     <= 8'h00;
      stable_ff <= 8'h00;
    end else begin
      s1_ff     <= pin_i;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      stable_ff <= (s2_ff & s3_ff) | (stable_ff & (s2_ff | s3_ff));
    end
  end

  assign level_o = stable_ff;
  assign cell_o  = cell_ff;

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    for (k = 0; k < 8; k = k + 1) begin
      case (mode_i[2*k +: 2])
        `CAP_LATCH: nxt_cell[k] = strobe_i ? stable_ff[k] : cell_ff[k];
        `CAP_EDGE:  nxt_cell[k] = (strobe_i & ~strobe_dly_ff[k]) ?
                                  stable_ff[k] : cell_ff[k];
        default:    nxt_cell[k] = stable_ff[k];
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cell_ff       <= 8'h00;
      strobe_dly_ff <= 8'h00;
    end else begin
      cell_ff       <= nxt_cell;
      strobe_dly_ff <= {8{strobe_i}};
    end
  end

endmodule // capture_cell_port

// [logic/io_ports.v]
// Four configurable I/O ports with output mux and readback; capture cells on ports A to C only.
// Assumes an AHB-Lite master, single word transfers; logic cells are external inputs.
`timescale 1ns/1ps
`include "io_ports_regs.vh"

module io_ports #(
  // Build-time pin functions, fixed by programming
  parameter [15:0] FN_A        = 16'h0000,
  parameter [15:0] FN_B        = 16'h0000,
  parameter [15:0] FN_C        = 16'h0000,
  parameter [5:0]  FN_D        = 6'h00,
  parameter [7:0]  ADDR_IN_A   = 8'h00,
  parameter        NONMUX_BUS  = 1'b0,
  parameter        TEST_PORT_C = 1'b0
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [11:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // Host bus address and strobe
  input  wire [15:0] host_addr_i,
  input  wire        address_latch_strobe_i,
  input  wire        capture_pt_i,
  // Programmable logic
  input  wire [7:0]  macrocell_group_low_i,
  input  wire [7:0]  macrocell_group_high_i,
  input  wire [2:0]  extra_chip_select_outputs_i,
  input  wire [27:0] logic_oe_pt_i,
  input  wire [7:0]  data_bus_i,
  input  wire        data_bus_oe_i,
  // Serial test port on port C
  input  wire        test_active_i,
  input  wire [7:0]  test_do_i,
  input  wire [7:0]  test_oe_i,
  // Pins
  input  wire [26:0] pin_i,
  output reg  [26:0] pin_o,
  output reg  [26:0] pin_oe_n_o,
  // Captured inputs to the logic array
  output reg  [23:0] input_capture_cell_o
);

  localparam [7:0] FIX_A = 8'h00;

  reg  [7:0]  out_a_ff;
  reg  [7:0]  out_b_ff;
  reg  [7:0]  out_c_ff;
  reg  [2:0]  out_d_ff;
  reg  [7:0]  dir_a_ff;
  reg  [7:0]  dir_b_ff;
  reg  [7:0]  dir_c_ff;
  reg  [2:0]  dir_d_ff;
  reg  [7:0]  mode_a_ff;
  reg  [7:0]  mode_b_ff;
  reg  [15:0] cap_a_ff;
  reg  [15:0] cap_b_ff;
  reg  [15:0] cap_c_ff;
  reg  [7:0]  addr_lat_ff;
  reg         ph_ff;
  reg         ph_wr_ff;
  reg  [11:0] ph_addr_ff;
  reg  [31:0] nxt_rdata;
  reg  [26:0] nxt_pin;
  reg  [26:0] nxt_oe_n;
  reg  [7:0]  src_a;
  reg  [7:0]  src_b;
  reg  [7:0]  src_c;
  reg  [2:0]  src_d;
  reg  [26:0] pin_dir;
  reg  [26:0] pin_logic;
  wire [7:0]  lvl_a;
  wire [7:0]  lvl_b;
  wire [7:0]  lvl_c;
  wire [7:0]  lvl_d;
  wire [7:0]  cell_a;
  wire [7:0]  cell_b;
  wire [7:0]  cell_c;
  wire [7:0]  addr_sel_a;
  wire [7:0]  addr_sel_b;
  wire [7:0]  wbyte;
  wire        strobe;
  integer     k;

  assign wbyte  = hwdata_i[7:0];
  assign strobe = address_latch_strobe_i | capture_pt_i;

  // Port A carries the data bus of a non-multiplexed host, so no address out there
  assign addr_sel_a = NONMUX_BUS ? 8'h00 : mode_a_ff;
  assign addr_sel_b = mode_b_ff;

  ////////////////////////////////////////////////////////////////////////
  // Address latch: follows the host address while the strobe is high;
  // a non-multiplexed host has a steady address, so it is tracked always
  always @(posedge ref_clk_i) begin
    if (rst_i)
      addr_lat_ff <= 8'h00;
    else if (address_latch_strobe_i || NONMUX_BUS)
      addr_lat_ff <= host_addr_i[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ph_ff      <= 1'b0;
      ph_wr_ff   <= 1'b0;
      ph_addr_ff <= 12'h000;
    end else if (hready_i) begin
      ph_ff      <= hsel_i & htrans_i[1];
      ph_wr_ff   <= hwrite_i;
      ph_addr_ff <= haddr_i;
    end
  end

  // Configuration registers, all clear at reset
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_a_ff  <= `CFG_RESET;
      out_b_ff  <= `CFG_RESET;
      out_c_ff  <= `CFG_RESET;
      out_d_ff  <= 3'h0;
      dir_a_ff  <= `CFG_RESET;
      dir_b_ff  <= `CFG_RESET;
      dir_c_ff  <= `CFG_RESET;
      dir_d_ff  <= 3'h0;
      mode_a_ff <= `CFG_RESET;
      mode_b_ff <= `CFG_RESET;
      cap_a_ff  <= 16'h0000;
      cap_b_ff  <= 16'h0000;
      cap_c_ff  <= 16'h0000;
    end else if (ph_ff && ph_wr_ff) begin
      case (ph_addr_ff)
        `OFS_OUT_A:  out_a_ff  <= wbyte;
        `OFS_OUT_B:  out_b_ff  <= wbyte;
        `OFS_OUT_C:  out_c_ff  <= wbyte;
        `OFS_OUT_D:  out_d_ff  <= wbyte[2:0];
        `OFS_DIR_A:  dir_a_ff  <= wbyte;
        `OFS_DIR_B:  dir_b_ff  <= wbyte;
        `OFS_DIR_C:  dir_c_ff  <= wbyte;
        `OFS_DIR_D:  dir_d_ff  <= wbyte[2:0];
        `OFS_MODE_A: mode_a_ff <= wbyte;
        `OFS_MODE_B: mode_b_ff <= wbyte;
        `OFS_CAP_A:  cap_a_ff  <= hwdata_i[15:0];
        `OFS_CAP_B:  cap_b_ff  <= hwdata_i[15:0];
        `OFS_CAP_C:  cap_c_ff  <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback buffer: one source per address, unmapped reads zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      case (haddr_i)
        `OFS_IN_A:   nxt_rdata = {24'h0, lvl_a};
        `OFS_IN_B:   nxt_rdata = {24'h0, lvl_b};
        `OFS_IN_C:   nxt_rdata = {24'h0, lvl_c};
        `OFS_IN_D:   nxt_rdata = {29'h0, lvl_d[2:0]};
        `OFS_OUT_A:  nxt_rdata = {24'h0, out_a_ff};
        `OFS_OUT_B:  nxt_rdata = {24'h0, out_b_ff};
        `OFS_OUT_C:  nxt_rdata = {24'h0, out_c_ff};
        `OFS_OUT_D:  nxt_rdata = {29'h0, out_d_ff};
        `OFS_DIR_A:  nxt_rdata = {24'h0, dir_a_ff};
        `OFS_DIR_B:  nxt_rdata = {24'h0, dir_b_ff};
        `OFS_DIR_C:  nxt_rdata = {24'h0, dir_c_ff};
        `OFS_DIR_D:  nxt_rdata = {29'h0, dir_d_ff};
        `OFS_MODE_A: nxt_rdata = {24'h0, mode_a_ff};
        `OFS_MODE_B: nxt_rdata = {24'h0, mode_b_ff};
        `OFS_CAP_A:  nxt_rdata = {16'h0, cap_a_ff};
        `OFS_CAP_B:  nxt_rdata = {16'h0, cap_b_ff};
        `OFS_CAP_C:  nxt_rdata = {16'h0, cap_c_ff};
        `OFS_CELL_A: nxt_rdata = {24'h0, cell_a};
        `OFS_CELL_B: nxt_rdata = {24'h0, cell_b};
        `OFS_CELL_C: nxt_rdata = {24'h0, cell_c};
        `OFS_MCELL_LO: nxt_rdata = {24'h0, macrocell_group_low_i};
        `OFS_MCELL_HI: nxt_rdata = {24'h0, macrocell_group_high_i};
        default:     nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hrdata_o    <= nxt_rdata;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output mux per pin; each pin serves one fixed function, except port C pins while the test port is active
  always @* begin
    for (k = 0; k < 8; k = k + 1) begin
      case (FN_A[2*k +: 2])
        `FN_LOGIC: src_a[k] = macrocell_group_low_i[k];
        `FN_DATA:  src_a[k] = data_bus_i[k];
        default:   src_a[k] = addr_sel_a[k] ? addr_lat_ff[k] : out_a_ff[k];
      endcase
      case (FN_B[2*k +: 2])
        `FN_LOGIC: src_b[k] = macrocell_group_low_i[k];
        default:   src_b[k] = addr_sel_b[k] ? addr_lat_ff[k] : out_b_ff[k];
      endcase
      case (FN_C[2*k +: 2])
        `FN_LOGIC: src_c[k] = macrocell_group_high_i[k];
        default:   src_c[k] = out_c_ff[k];
      endcase
      if (TEST_PORT_C && test_active_i)
        src_c[k] = test_do_i[k];
    end
    for (k = 0; k < 3; k = k + 1) begin
      case (FN_D[2*k +: 2])
        `FN_CS:  src_d[k] = extra_chip_select_outputs_i[k];
        default: src_d[k] = out_d_ff[k];
      endcase
    end
  end

  // Driver enable is the OR of product term and direction bit, except on data-bus, address-in and active test-port pins
  always @* begin
    pin_dir = {dir_d_ff, dir_c_ff, dir_b_ff, dir_a_ff};
    for (k = 0; k < 8; k = k + 1) begin
      pin_logic[k]      = (FN_A[2*k +: 2] != `FN_HOST);
      pin_logic[8 + k]  = (FN_B[2*k +: 2] != `FN_HOST);
      pin_logic[16 + k] = (FN_C[2*k +: 2] != `FN_HOST);
    end
    for (k = 0; k < 3; k = k + 1)
      pin_logic[24 + k] = (FN_D[2*k +: 2] != `FN_HOST);
    for (k = 0; k < 27; k = k + 1)
      // Undefined terms come in low, so direction alone decides
      nxt_oe_n[k] = ~(logic_oe_pt_i[k] | pin_dir[k]);
    for (k = 0; k < 8; k = k + 1) begin
      if (FN_A[2*k +: 2] == `FN_DATA)
        nxt_oe_n[k] = ~data_bus_oe_i;
      if (ADDR_IN_A[k] | FIX_A[k])
        nxt_oe_n[k] = 1'b1;
      if (TEST_PORT_C && test_active_i)
        nxt_oe_n[16 + k] = ~test_oe_i[k];
    end
    nxt_pin = {src_d, src_c, src_b, src_a};
    if (pin_logic[0]) nxt_pin[0] = src_a[0];
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_o      <= 27'h0000000;
      pin_oe_n_o <= 27'h7ffffff;
    end else begin
      pin_o      <= nxt_pin;
      pin_oe_n_o <= nxt_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  capture_cell_port u_cap_a (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (pin_i[7:0]),
    .strobe_i  (strobe),
    .mode_i    (cap_a_ff),
    .level_o   (lvl_a),
    .cell_o    (cell_a)
  );

  capture_cell_port u_cap_b (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (pin_i[15:8]),
    .strobe_i  (strobe),
    .mode_i    (cap_b_ff),
    .level_o   (lvl_b),
    .cell_o    (cell_b)
  );

  capture_cell_port u_cap_c (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (pin_i[23:16]),
    .strobe_i  (strobe),
    .mode_i    (cap_c_ff),
    .level_o   (lvl_c),
    .cell_o    (cell_c)
  );

  // Port D has no capture cells; only the synchronised level is used so that
  // a read never returns a pin caught in mid-change
  capture_cell_port u_sync_d (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({5'h00, pin_i[26:24]}),
    .strobe_i  (1'b0),
    .mode_i    (16'h0000),
    .level_o   (lvl_d),
    .cell_o    ()
  );

  always @(posedge ref_clk_i) begin
    if (rst_i)
      input_capture_cell_o <= 24'h000000;
    else
      input_capture_cell_o <= {cell_c, cell_b, cell_a};
  end

endmodule // io_ports

// [bench/io_ports_asserts.sv]
// Port-level checker for the I/O port block.
// Assumes default build functions: every pin is a host pin.
`timescale 1ns/1ps
`include "io_ports_regs.vh"
module io_ports_asserts (
  // Clock and reset
  input wire        ref_clk_i,
  input wire        rst_i,
  // Bus
  input wire        hsel_i,
  input wire [11:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  // Pins
  input wire [27:0] logic_oe_pt_i,
  input wire [26:0] pin_i,
  input wire [26:0] pin_o,
  input wire [26:0] pin_oe_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  wire d_reg = haddr_i == `OFS_IN_D || haddr_i == `OFS_OUT_D || haddr_i == `OFS_DIR_D;
  wire cap_reg = haddr_i >= `OFS_CAP_A && haddr_i < `OFS_CELL_A;
  // Port D reads a synchronised level, so it is only checked once the pins were quiet
  reg  [2:0] d_prev;
  reg  [2:0] d_quiet;
  always @(posedge ref_clk_i) begin
    d_prev <= pin_i[26:24];
    if (rst_i || pin_i[26:24] != d_prev)
      d_quiet <= 3'h0;
    else if (d_quiet != 3'h7)
      d_quiet <= d_quiet + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  rdy_high_a: assert property (hreadyout_o) else $error("slave stretched");
  resp_okay_a: assert property (!hresp_o) else $error("error response");
  reset_state_a: assert property ($fell(rst_i) |-> &pin_oe_n_o && pin_o == 27'h0
    && hrdata_o == 32'h0) else $error("bad state after reset");
  pt_drive_a: assert property (!$past(rst_i) |->
    ($past(logic_oe_pt_i[26:0]) & pin_oe_n_o) == 27'h0) else $error("term did not drive");
  d_upper_a: assert property (rd && d_reg |=> hrdata_o[31:3] == 29'h0)
    else $error("port D high bits set");
  narrow_read_a: assert property (rd && !cap_reg |=> hrdata_o[31:8] == 24'h0)
    else $error("byte register high bits set");
  cap_upper_a: assert property (rd && cap_reg |=> hrdata_o[31:16] == 16'h0)
    else $error("capture mode high bits set");
  unmapped_a: assert property (rd && haddr_i > `OFS_MCELL_HI |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  in_d_level_a: assert property (rd && haddr_i == `OFS_IN_D && d_quiet >= 3'h3 &&
    pin_i[26:24] == d_prev |=> hrdata_o[2:0] == $past(pin_i[26:24]))
    else $error("port D input wrong");
  cover property (rd && haddr_i == `OFS_OUT_B);
  cover property (|(logic_oe_pt_i[26:0] & ~pin_oe_n_o));
  cover property ($fell(pin_oe_n_o[8]));
endmodule // io_ports_asserts
bind io_ports io_ports_asserts io_ports_asserts_inst (.ref_clk_i, .rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .logic_oe_pt_i, .pin_i, .pin_o, .pin_oe_n_o);

// [bench/host_mcu_model.sv]
// Host controller model: AHB-Lite single word master and address strobe.
// Assumes one slave whose hreadyout is fed back as hready_i.
`timescale 1ns/1ps
module host_mcu_model (
  // Clock and bus answer
  input  wire        ref_clk_i,
  input  wire        hready_i,
  input  wire [31:0] hrdata_i,
  // Bus request
  output reg         hsel_o,
  output reg  [11:0] haddr_o,
  output reg  [1:0]  htrans_o,
  output reg         hwrite_o,
  output reg  [2:0]  hsize_o,
  output reg  [31:0] hwdata_o,
  // Host address bus
  output reg  [15:0] host_addr_o,
  output reg         strobe_o
);
  initial begin
    {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o, host_addr_o, strobe_o} = 0;
    hsize_o = 3'h2;
  end
  // Host pins only, so direction is never set on a logic input
  task xfer(input w, input [11:0] a, input [15:0] d, output [31:0] q);
    begin
      @(posedge ref_clk_i);
      {hsel_o, htrans_o, haddr_o, hwrite_o} <= {1'b1, 2'h2, a, w};
      @(posedge ref_clk_i);
      while (hready_i !== 1'b1) @(posedge ref_clk_i);
      // Released address shows its inverse, not a stale copy
      {hsel_o, htrans_o, haddr_o, hwdata_o} <= {1'b0, 2'h0, ~a, ~d, d};
      @(posedge ref_clk_i);
      while (hready_i !== 1'b1) @(posedge ref_clk_i);
      q = hrdata_i;
    end
  endtask
  // Runs from internal code, so address out is set up before use
  task latch(input [15:0] a);
    begin
      @(posedge ref_clk_i);
      {host_addr_o, strobe_o} <= {a, 1'b1};
      @(posedge ref_clk_i);
      strobe_o <= 1'b0;
      @(posedge ref_clk_i);
      host_addr_o <= ~a;
    end
  endtask
endmodule // host_mcu_model

// [bench/tb_multi_function_io_ports.sv]
// Self-checking bench for the I/O port block with a host master model.
// Assumes default build functions and a checker bound to the block.
`timescale 1ns/1ps
`include "io_ports_regs.vh"
module tb_multi_function_io_ports;
  reg         clk, rst;
  reg  [26:0] pin, p1;
  reg  [27:0] pt;
  reg  [7:0]  mc_lo, mc_hi, tdo, toe, d;
  reg  [2:0]  ecs;
  reg  [15:0] la;
  reg  [11:0] a;
  reg  [31:0] q;
  reg  [7:0]  rv [0:9];
  wire        hsel, hwrite, hready, hresp, stb;
  wire [11:0] haddr;
  wire [1:0]  htrans;
  wire [2:0]  hsize;
  wire [31:0] hwdata, hrdata;
  wire [15:0] host_addr;
  wire [26:0] pin_o, oe_n;
  wire [23:0] cells;
  integer     seed, err_total, n_checks, i, k;
  io_ports io_ports_inst (.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .host_addr_i(host_addr), .address_latch_strobe_i(stb), .capture_pt_i(1'b0),
    .macrocell_group_low_i(mc_lo), .macrocell_group_high_i(mc_hi),
    .extra_chip_select_outputs_i(ecs), .logic_oe_pt_i(pt), .data_bus_i(8'h00),
    .data_bus_oe_i(1'b0), .test_active_i(1'b0), .test_do_i(tdo), .test_oe_i(toe),
    .pin_i(pin), .pin_o(pin_o), .pin_oe_n_o(oe_n), .input_capture_cell_o(cells));
  host_mcu_model host_mcu_model_inst (.ref_clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata), .host_addr_o(host_addr), .strobe_o(stb));
  ////////////////////////////////////////////////////////////////////////////
  function [7:0] rmask(input integer n);
    rmask = (n == 3 || n == 7) ? 8'h07 : 8'hff;
  endfunction
  function [26:0] exp_oe_n(input [27:0] p);
    exp_oe_n = ~({rv[7][2:0], rv[6], rv[5], rv[4]} | p[26:0]);
  endfunction
  // Mode bit picks the latched low address byte on ports A and B
  function [26:0] exp_pin(input integer u);
    exp_pin = {rv[3][2:0], rv[2], (rv[9] & la[7:0]) | (~rv[9] & rv[1]),
      (rv[8] & la[7:0]) | (~rv[8] & rv[0])};
  endfunction
  function [31:0] exp_in(input [11:0] x);
    exp_in = (pin >> ((x >= `OFS_CELL_A ? x - `OFS_CELL_A : x) * 2)) &
      (x == `OFS_IN_D ? 32'h7 : 32'hff);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] x, input [15:0] v);
    host_mcu_model_inst.xfer(1'b1, x, v, q);
  endtask
  task rd(input [11:0] x);
    host_mcu_model_inst.xfer(1'b0, x, 16'h0, q);
  endtask
  task give_verdict;
    begin
      $display("checks %0d, errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    {seed, err_total, n_checks} = {32'h3f8a5275, 64'h0};
    {rst, pin, pt, mc_lo, mc_hi, ecs, tdo, toe, la} = {1'b1, 106'h0};
    for (i = 0; i < 10; i = i + 1) rv[i] = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk({5'h0, oe_n}, 32'h07ffffff);
    for (a = 12'h000; a < 12'h050; a = a + 12'h004) begin
      rd(a);
      chk(q, 32'h0);
    end
    la = $random(seed);
    host_mcu_model_inst.latch(la);
    // First two passes hit the port D registers with all ones
    for (i = 0; i < 30; i = i + 1) begin
      k = (i < 2) ? 3 + 4 * i : {$random(seed)} % 10;
      d = (i < 2) ? 8'hff : $random(seed);
      a = 12'h010 + 12'h004 * k[11:0];
      rv[k] = d & rmask(k);
      wr(a, {~d, d});
      rd(a);
      chk(q, {24'h0, rv[k]});
      chk({5'h0, oe_n}, {5'h0, exp_oe_n(28'h0)});
      chk({5'h0, pin_o & ~oe_n}, {5'h0, exp_pin(0) & ~exp_oe_n(28'h0)});
    end
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk);
      pt <= $random(seed);
      {mc_lo, mc_hi, ecs, tdo, toe} <= {$random(seed), $random(seed)};
      repeat (2) @(posedge clk);
      chk({5'h0, oe_n}, {5'h0, exp_oe_n(pt)});
      rd(`OFS_MCELL_LO);
      chk(q, {24'h0, mc_lo});
      rd(`OFS_MCELL_HI);
      chk(q, {24'h0, mc_hi});
    end
    pt <= 28'h0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      pin <= $random(seed);
      repeat (7) @(posedge clk);
      chk({8'h0, cells}, {8'h0, pin[23:0]});
      for (a = 12'h000; a < 12'h050; a = a + 12'h004) begin
        if (a < 12'h010 || a >= `OFS_CELL_A) begin
          rd(a);
          chk(q, exp_in(a));
        end
      end
    end
    // Port A latches, port B samples on the strobe edge, port C stays direct
    wr(`OFS_CAP_A, 16'h5555);
    wr(`OFS_CAP_B, 16'haaaa);
    p1 = pin;
    @(posedge clk);
    pin <= ~p1;
    repeat (7) @(posedge clk);
    la = $random(seed);
    host_mcu_model_inst.latch(la);
    // Pins swing back after the strobe: held cells keep the strobed value
    @(posedge clk);
    pin <= p1;
    repeat (7) @(posedge clk);
    rd(`OFS_CELL_A);
    chk(q, {24'h0, ~p1[7:0]});
    rd(`OFS_CELL_B);
    chk(q, {24'h0, ~p1[15:8]});
    rd(`OFS_CELL_C);
    chk(q, {24'h0, p1[23:16]});
    rd(`OFS_CAP_B);
    chk(q, 32'h0000aaaa);
    wr(12'h058, 16'hffff);
    rd(12'h058);
    chk(q, 32'h0);
    rd(`OFS_OUT_A);
    chk(q, {24'h0, rv[0]});
    give_verdict;
  end
endmodule // tb_multi_function_io_ports
